// file: ifsb_flag_word.sv
/*
 One 16-bit word of sticky interrupt flags.
 Assumes one-cycle request pulses synchronous to clk and a write
 strobe that lasts one cycle per bus write.
*/
`timescale 1ns/1ps
`include "ifsb_params.svh"
module ifsb_flag_word #(
	parameter logic [15:0] IMPL = 16'hffff
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic [15:0] req,
	output logic      [15:0] flags
);
	ifsb_pkg::ifsb_word_t flag_reg;
	ifsb_pkg::ifsb_word_t flag_next;

	// Request ORed in after the write so a pulse never gets lost
	always_comb begin
		flag_next = flag_reg;
		if (wr_en) begin
			flag_next = wr_data;
		end
		flag_next = (flag_next | req) & IMPL;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_reg <= `IFSB_RST;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flags = flag_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_REQ_SETS: assert property (
		|(req & IMPL) |=>
		((flags & $past(req) & IMPL) == ($past(req) & IMPL)))
		else $error("request pulse did not set its flag");
	AST_UNIMPL_ZERO: assert property (
		(flags & ~IMPL) == 16'h0000)
		else $error("unimplemented flag bit reads one");
	AST_WRITE_TAKES: assert property (
		wr_en |=> flags == (($past(wr_data) | $past(req)) & IMPL))
		else $error("flag write not taken");
	AST_FLAG_HOLDS: assert property (
		!wr_en && req == 16'h0000 |=> $stable(flags))
		else $error("flag changed without cause");
endmodule

// file: ifsb_params.svh
/*
 Constants of the interrupt flag status bank: register offsets on the
 APB slave, masks of implemented flag bits, reset value.
 Assumes inclusion by its bare name from the bank's design files.
*/
`ifndef IFSB_PARAMS_SVH
`define IFSB_PARAMS_SVH
`define IFSB_OFF_FLAG0 8'h00
`define IFSB_OFF_FLAG1 8'h04
`define IFSB_OFF_FLAG2 8'h08
`define IFSB_OFF_FLAG3 8'h0c
`define IFSB_OFF_EN0   8'h10
`define IFSB_OFF_EN1   8'h14
`define IFSB_OFF_EN2   8'h18
`define IFSB_OFF_EN3   8'h1c
`define IFSB_OFF_ACT   8'h20
`define IFSB_IMPL0     16'h0007
`define IFSB_IMPL1     16'hfffb
`define IFSB_IMPL2     16'hdfff
`define IFSB_IMPL3     16'h39ff
`define IFSB_RST       16'h0000
`endif

// file: ifsb_pkg.sv
/*
 Types of the interrupt flag status bank.
 Assumes nothing of its surroundings.
*/
package ifsb_pkg;
	typedef logic [15:0] ifsb_word_t;
	// Register selected by an APB address
	typedef enum {
		IFSB_SEL_NONE,
		IFSB_SEL_FLAG0,
		IFSB_SEL_FLAG1,
		IFSB_SEL_FLAG2,
		IFSB_SEL_FLAG3,
		IFSB_SEL_EN0,
		IFSB_SEL_EN1,
		IFSB_SEL_EN2,
		IFSB_SEL_EN3,
		IFSB_SEL_ACT
	} ifsb_sel_t;
endpackage

// file: ifsb_src_model.sv
/*
 Model of the on-chip peripheral sources that feed the flag bank.
 Assumes the bench asks for one pulse at a time, index = word*16 + bit.
*/
`timescale 1ns/1ps
module ifsb_src_model (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        fire,
	input  wire logic [5:0]  idx,
	output logic      [63:0] req
);
	// One-cycle pulse per command; a held level would hide stickiness
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req <= 64'h0;
		end else begin
			req <= fire ? (64'h1 << idx) : 64'h0;
		end
	end
endmodule

// file: ifsb_top.sv
/*
 Interrupt flag status bank: four flag words, four enable words and a
 read-only view of the enabled pending flags in bits 7-0 of each word, all on an APB slave, with one
 level interrupt toward the CPU.
 Assumes request pulses of one cycle, synchronous to clk, and an APB
 master on the same clock.
*/
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "ifsb_params.svh"
module ifsb_top (
	input  wire logic        clk,
	input  wire logic        resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Word 0 sources
	input  wire logic        compare1_req,
	input  wire logic        capture1_req,
	input  wire logic        ext_pin0_req,
	// Word 1 sources
	input  wire logic        uart2_tx_req,
	input  wire logic        uart2_rx_req,
	input  wire logic        ext_pin2_req,
	input  wire logic        timer5_req,
	input  wire logic        timer4_req,
	input  wire logic        compare4_req,
	input  wire logic        compare3_req,
	input  wire logic        dma_ch2_done_req,
	input  wire logic        capture8_req,
	input  wire logic        capture7_req,
	input  wire logic        adc2_done_req,
	input  wire logic        ext_pin1_req,
	input  wire logic        pin_change_req,
	input  wire logic        i2c1_master_req,
	input  wire logic        i2c1_slave_req,
	// Word 2 sources
	input  wire logic        timer6_req,
	input  wire logic        dma_ch4_done_req,
	input  wire logic        compare8_req,
	input  wire logic        compare7_req,
	input  wire logic        compare6_req,
	input  wire logic        compare5_req,
	input  wire logic        capture6_req,
	input  wire logic        capture5_req,
	input  wire logic        capture4_req,
	input  wire logic        capture3_req,
	input  wire logic        dma_ch3_done_req,
	input  wire logic        can1_event_req,
	input  wire logic        can1_rx_ready_req,
	input  wire logic        spi2_event_req,
	input  wire logic        spi2_error_req,
	// Word 3 sources
	input  wire logic        dma_ch5_done_req,
	input  wire logic        codec_if_event_req,
	input  wire logic        codec_if_error_req,
	input  wire logic        can2_event_req,
	input  wire logic        can2_rx_ready_req,
	input  wire logic        ext_pin4_req,
	input  wire logic        ext_pin3_req,
	input  wire logic        timer9_req,
	input  wire logic        timer8_req,
	input  wire logic        i2c2_master_req,
	input  wire logic        i2c2_slave_req,
	input  wire logic        timer7_req,
	// Interrupt to the CPU
	output logic             irq_out
);
	localparam ifsb_pkg::ifsb_word_t IMPL [4] = '{
		`IFSB_IMPL0, `IFSB_IMPL1, `IFSB_IMPL2, `IFSB_IMPL3
	};

	ifsb_pkg::ifsb_word_t req_w   [4];
	ifsb_pkg::ifsb_word_t flag_w  [4];
	ifsb_pkg::ifsb_word_t act_w   [4];
	ifsb_pkg::ifsb_word_t en_reg  [4];
	ifsb_pkg::ifsb_word_t en_next [4];
	logic                 fwr     [4];
	logic [31:0]          prdata_reg;
	logic [31:0]          prdata_next;
	logic                 irq_reg;
	logic                 irq_next;
	ifsb_pkg::ifsb_sel_t  rsel;
	ifsb_pkg::ifsb_sel_t  wsel;
	logic                 rd_setup;
	logic                 wr_acc;

	// Address decode, shared by the read and write paths
	function automatic ifsb_pkg::ifsb_sel_t sel_of(
		input logic [7:0] a
	);
		case (a)
			`IFSB_OFF_FLAG0: sel_of = ifsb_pkg::IFSB_SEL_FLAG0;
			`IFSB_OFF_FLAG1: sel_of = ifsb_pkg::IFSB_SEL_FLAG1;
			`IFSB_OFF_FLAG2: sel_of = ifsb_pkg::IFSB_SEL_FLAG2;
			`IFSB_OFF_FLAG3: sel_of = ifsb_pkg::IFSB_SEL_FLAG3;
			`IFSB_OFF_EN0:   sel_of = ifsb_pkg::IFSB_SEL_EN0;
			`IFSB_OFF_EN1:   sel_of = ifsb_pkg::IFSB_SEL_EN1;
			`IFSB_OFF_EN2:   sel_of = ifsb_pkg::IFSB_SEL_EN2;
			`IFSB_OFF_EN3:   sel_of = ifsb_pkg::IFSB_SEL_EN3;
			`IFSB_OFF_ACT:   sel_of = ifsb_pkg::IFSB_SEL_ACT;
			default:         sel_of = ifsb_pkg::IFSB_SEL_NONE;
		endcase
	endfunction

	// Word 0: only the low three flags belong to this bank
	assign req_w[0] = {
		13'h0000,
		compare1_req,
		capture1_req,
		ext_pin0_req
	};

	// Word 1: bit 2 has no source and stays zero
	assign req_w[1] = {
		uart2_tx_req,
		uart2_rx_req,
		ext_pin2_req,
		timer5_req,
		timer4_req,
		compare4_req,
		compare3_req,
		dma_ch2_done_req,
		capture8_req,
		capture7_req,
		adc2_done_req,
		ext_pin1_req,
		pin_change_req,
		1'b0,
		i2c1_master_req,
		i2c1_slave_req
	};

	// Word 2: bit 13 has no source
	assign req_w[2] = {
		timer6_req,
		dma_ch4_done_req,
		1'b0,
		compare8_req,
		compare7_req,
		compare6_req,
		compare5_req,
		capture6_req,
		capture5_req,
		capture4_req,
		capture3_req,
		dma_ch3_done_req,
		can1_event_req,
		can1_rx_ready_req,
		spi2_event_req,
		spi2_error_req
	};

	// Word 3: bits 15-14 and 10-9 have no source
	assign req_w[3] = {
		2'b00,
		dma_ch5_done_req,
		codec_if_event_req,
		codec_if_error_req,
		2'b00,
		can2_event_req,
		can2_rx_ready_req,
		ext_pin4_req,
		ext_pin3_req,
		timer9_req,
		timer8_req,
		i2c2_master_req,
		i2c2_slave_req,
		timer7_req
	};

	// Bus phases; zero wait states since reads are fetched in setup
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_acc   = psel && penable && pwrite;
	assign rsel     = sel_of(paddr);
	assign wsel     = rsel;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable &&
		(rsel == ifsb_pkg::IFSB_SEL_NONE);

	// Write strobes toward the flag words
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			fwr[i] = 1'b0;
		end
		if (wr_acc) begin
			case (wsel)
				ifsb_pkg::IFSB_SEL_FLAG0: fwr[0] = 1'b1;
				ifsb_pkg::IFSB_SEL_FLAG1: fwr[1] = 1'b1;
				ifsb_pkg::IFSB_SEL_FLAG2: fwr[2] = 1'b1;
				ifsb_pkg::IFSB_SEL_FLAG3: fwr[3] = 1'b1;
				default: ;
			endcase
		end
	end

	// Flag words; a request in the write cycle wins over the write
	for (genvar g = 0; g < 4; g++) begin : gen_word
		ifsb_flag_word #(
			.IMPL (IMPL[g])
		) u_word (
			.clk     (clk),
			.resetn  (resetn),
			.wr_en   (fwr[g]),
			.wr_data (pwdata[15:0]),
			.req     (req_w[g]),
			.flags   (flag_w[g])
		);
		assign act_w[g] = flag_w[g] & en_reg[g];
	end

	// Enable words, masked like the flags they gate
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			en_next[i] = en_reg[i];
		end
		if (wr_acc) begin
			case (wsel)
				ifsb_pkg::IFSB_SEL_EN0:
					en_next[0] = pwdata[15:0] & IMPL[0];
				ifsb_pkg::IFSB_SEL_EN1:
					en_next[1] = pwdata[15:0] & IMPL[1];
				ifsb_pkg::IFSB_SEL_EN2:
					en_next[2] = pwdata[15:0] & IMPL[2];
				ifsb_pkg::IFSB_SEL_EN3:
					en_next[3] = pwdata[15:0] & IMPL[3];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 4; i++) begin
				en_reg[i] <= `IFSB_RST;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				en_reg[i] <= en_next[i];
			end
		end
	end

	// Read data captured in setup so it comes from a flop
	always_comb begin
		prdata_next = prdata_reg;
		if (rd_setup) begin
			prdata_next = 32'h0000_0000;
			case (rsel)
				ifsb_pkg::IFSB_SEL_FLAG0:
					prdata_next[15:0] = flag_w[0];
				ifsb_pkg::IFSB_SEL_FLAG1:
					prdata_next[15:0] = flag_w[1];
				ifsb_pkg::IFSB_SEL_FLAG2:
					prdata_next[15:0] = flag_w[2];
				ifsb_pkg::IFSB_SEL_FLAG3:
					prdata_next[15:0] = flag_w[3];
				ifsb_pkg::IFSB_SEL_EN0:
					prdata_next[15:0] = en_reg[0];
				ifsb_pkg::IFSB_SEL_EN1:
					prdata_next[15:0] = en_reg[1];
				ifsb_pkg::IFSB_SEL_EN2:
					prdata_next[15:0] = en_reg[2];
				ifsb_pkg::IFSB_SEL_EN3:
					prdata_next[15:0] = en_reg[3];
				ifsb_pkg::IFSB_SEL_ACT:
					prdata_next = {
						act_w[3][7:0], act_w[2][7:0],
						act_w[1][7:0], act_w[0][7:0]
					};
				default: ;
			endcase
		end
	end

	// Interrupt level registered to keep a glitch-free CPU input
	always_comb begin
		irq_next = (|act_w[0]) || (|act_w[1]) ||
			(|act_w[2]) || (|act_w[3]);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_reg <= 32'h0000_0000;
			irq_reg    <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			irq_reg    <= irq_next;
		end
	end

	assign prdata  = prdata_reg;
	assign irq_out = irq_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_rd_flag1;
		psel && !penable && !pwrite && paddr == `IFSB_OFF_FLAG1;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	AST_READ_FLAG1: assert property (
		s_rd_flag1 ##1 s_access |->
		prdata[15:0] == $past(flag_w[1]) && prdata[31:16] == 16'h0000)
		else $error("flag word 1 read back wrong");
	// The active view packs four low bytes, so it alone fills the top half
	AST_READ_UPPER_ZERO: assert property (
		psel && penable && !pwrite && !pslverr &&
		paddr != `IFSB_OFF_ACT |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	AST_SLVERR: assert property (
		psel && penable &&
		sel_of(paddr) == ifsb_pkg::IFSB_SEL_NONE |-> pslverr)
		else $error("unmapped address not refused");
	AST_IRQ_ON_PULSE: assert property (
		compare1_req && en_reg[0][2] |=> ##1 irq_out)
		else $error("enabled request gave no interrupt");
	AST_IRQ_GATED: assert property (
		(en_reg[0] == 16'h0000 && en_reg[1] == 16'h0000 &&
		en_reg[2] == 16'h0000 && en_reg[3] == 16'h0000)
		[*2] |-> !irq_out)
		else $error("interrupt with all enables low");
	AST_UART2_TX_POS: assert property (
		uart2_tx_req |=> flag_w[1][15])
		else $error("uart2 tx flag misplaced");
	AST_W1_BIT2_ZERO: assert property (
		!flag_w[1][2])
		else $error("word 1 bit 2 set");
	AST_W2_BIT13_ZERO: assert property (
		!flag_w[2][13])
		else $error("word 2 bit 13 set");
	AST_SPI2_ERR_POS: assert property (
		spi2_error_req |=> flag_w[2][0])
		else $error("spi2 error flag misplaced");
	AST_W3_GAPS_ZERO: assert property (
		flag_w[3][15:14] == 2'b00 && flag_w[3][10:9] == 2'b00)
		else $error("word 3 gap bits set");
	AST_TIMER7_POS: assert property (
		timer7_req |=> flag_w[3][0])
		else $error("timer 7 flag misplaced");
	AST_PIN0_POS: assert property (
		ext_pin0_req |=> flag_w[0][0] ##0 (flag_w[0][15:3] == 13'h0000))
		else $error("external pin 0 flag misplaced");
endmodule

// file: interrupt_flag_status_bank_tb_top.sv
/*
 Self-checking bench of the interrupt flag status bank.
 Assumes the APB offsets and masks of the bank's header file.
*/
`timescale 1ns/1ps
`include "ifsb_params.svh"
module interrupt_flag_status_bank_tb_top;
	logic        clk, resetn, psel, penable, pwrite, fire;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, irq_out;
	logic [5:0]  idx;
	logic [63:0] r;
	int          err_count, cmp_count;
	localparam logic [63:0] IMPL = {`IFSB_IMPL3, `IFSB_IMPL2,
		`IFSB_IMPL1, `IFSB_IMPL0};

	// Source bits sit at word*16 + bit, so a pulse maps to one flag
	ifsb_top u_ifsb_top (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.compare1_req(r[2]), .capture1_req(r[1]), .ext_pin0_req(r[0]),
		.uart2_tx_req(r[31]), .uart2_rx_req(r[30]), .ext_pin2_req(r[29]),
		.timer5_req(r[28]), .timer4_req(r[27]), .compare4_req(r[26]),
		.compare3_req(r[25]), .dma_ch2_done_req(r[24]),
		.capture8_req(r[23]), .capture7_req(r[22]), .adc2_done_req(r[21]),
		.ext_pin1_req(r[20]), .pin_change_req(r[19]),
		.i2c1_master_req(r[17]), .i2c1_slave_req(r[16]),
		.timer6_req(r[47]), .dma_ch4_done_req(r[46]), .compare8_req(r[44]),
		.compare7_req(r[43]), .compare6_req(r[42]), .compare5_req(r[41]),
		.capture6_req(r[40]), .capture5_req(r[39]), .capture4_req(r[38]),
		.capture3_req(r[37]), .dma_ch3_done_req(r[36]),
		.can1_event_req(r[35]), .can1_rx_ready_req(r[34]),
		.spi2_event_req(r[33]), .spi2_error_req(r[32]),
		.dma_ch5_done_req(r[61]), .codec_if_event_req(r[60]),
		.codec_if_error_req(r[59]), .can2_event_req(r[56]),
		.can2_rx_ready_req(r[55]), .ext_pin4_req(r[54]),
		.ext_pin3_req(r[53]), .timer9_req(r[52]), .timer8_req(r[51]),
		.i2c2_master_req(r[50]), .i2c2_slave_req(r[49]),
		.timer7_req(r[48]), .irq_out(irq_out));

	ifsb_src_model u_ifsb_src_model (.clk(clk), .resetn(resetn),
		.fire(fire), .idx(idx), .req(r));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; data and response taken at the pready edge only
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			end_of_test();
		end
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		fire <= 1'b1;
		idx <= 6'(i);
		@(posedge clk);
		fire <= 1'b0;
	endtask

	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0, q, e);
			chk("reset value", q, 32'h0);
		end
	endtask

	// All-ones then zero into flag and enable words; holes must stay 0
	task automatic t_rw;
		logic [31:0] q;
		logic        e;
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, 8'(k * 4), 32'hffffffff, q, e);
			apb(1'b0, 8'(k * 4), 32'h0, q, e);
			chk("ones", q, {16'h0, IMPL[(k % 4) * 16 +: 16]});
			apb(1'b1, 8'(k * 4), 32'h0, q, e);
			apb(1'b0, 8'(k * 4), 32'h0, q, e);
			chk("zeros", q, 32'h0);
		end
	endtask

	// Every source lands on its own bit and stays until written 0
	task automatic t_map;
		logic [31:0] q;
		logic        e;
		for (int i = 0; i < 64; i++) begin
			if (IMPL[i]) begin
				pulse(i);
				apb(1'b0, 8'((i / 16) * 4), 32'h0, q, e);
				chk("source bit", q, 32'h1 << (i % 16));
				chk("irq masked", {31'h0, irq_out}, 32'h0);
				apb(1'b1, 8'((i / 16) * 4), 32'h0, q, e);
				apb(1'b0, 8'((i / 16) * 4), 32'h0, q, e);
				chk("cleared", q, 32'h0);
			end
		end
	endtask

	// Interrupt follows flag and enable together
	task automatic t_irq;
		logic [31:0] q;
		logic        e;
		apb(1'b1, `IFSB_OFF_FLAG3, 32'h1, q, e);
		repeat (3) @(posedge clk);
		chk("irq off", {31'h0, irq_out}, 32'h0);
		apb(1'b1, `IFSB_OFF_EN3, 32'h1, q, e);
		repeat (3) @(posedge clk);
		chk("irq on", {31'h0, irq_out}, 32'h1);
		apb(1'b0, `IFSB_OFF_ACT, 32'h0, q, e);
		chk("active view", q, 32'h01000000);
		apb(1'b1, `IFSB_OFF_FLAG3, 32'h0, q, e);
		repeat (3) @(posedge clk);
		chk("irq cleared", {31'h0, irq_out}, 32'h0);
		pulse(48);
		repeat (20) @(posedge clk);
		chk("irq sticky", {31'h0, irq_out}, 32'h1);
		apb(1'b1, `IFSB_OFF_EN3, 32'h0, q, e);
		repeat (3) @(posedge clk);
		chk("irq masked", {31'h0, irq_out}, 32'h0);
		apb(1'b1, `IFSB_OFF_FLAG3, 32'h0, q, e);
		// Enabled compare 1 pulse must reach the CPU line
		apb(1'b1, `IFSB_OFF_EN0, 32'h4, q, e);
		pulse(2);
		repeat (3) @(posedge clk);
		chk("irq compare1", {31'h0, irq_out}, 32'h1);
		apb(1'b0, `IFSB_OFF_ACT, 32'h0, q, e);
		chk("active compare1", q, 32'h00000004);
		apb(1'b1, `IFSB_OFF_FLAG0, 32'h0, q, e);
		apb(1'b1, `IFSB_OFF_EN0, 32'h0, q, e);
		repeat (3) @(posedge clk);
		chk("irq compare1 off", {31'h0, irq_out}, 32'h0);
	endtask

	// Reset in mid-run wipes set flags, enables and the interrupt
	task automatic t_midreset;
		logic [31:0] q;
		logic        e;
		apb(1'b1, `IFSB_OFF_FLAG1, 32'hffffffff, q, e);
		apb(1'b1, `IFSB_OFF_EN1, 32'hffffffff, q, e);
		repeat (3) @(posedge clk);
		chk("irq before reset", {31'h0, irq_out}, 32'h1);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		apb(1'b0, `IFSB_OFF_FLAG1, 32'h0, q, e);
		chk("flags after reset", q, 32'h0);
		apb(1'b0, `IFSB_OFF_EN1, 32'h0, q, e);
		chk("enables after reset", q, 32'h0);
		chk("irq after reset", {31'h0, irq_out}, 32'h0);
	endtask

	task automatic t_err;
		logic [31:0] q;
		logic        e;
		apb(1'b0, 8'h24, 32'h0, q, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", q, 32'h0);
		apb(1'b1, `IFSB_OFF_ACT, 32'hffffffff, q, e);
		chk("view write err", {31'h0, e}, 32'h0);
		apb(1'b0, `IFSB_OFF_ACT, 32'h0, q, e);
		chk("view read only", q, 32'h0);
	endtask

	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fire = 1'b0;
		idx = 6'h00;
		err_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_rw();
		t_map();
		t_irq();
		t_err();
		t_midreset();
		end_of_test();
	end
endmodule
